// ---- hw/slpc_cfg_if.sv ----
// Interface carrying decoded configuration between decoder and top.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ns
`default_nettype none
interface slpc_cfg_if;
  import slpc_pkg::*;
  logic [7:0]                pin_control;
  logic [SLPC_NUM_COM-1:0]   com_drive;
  logic [SLPC_NUM_COM*2-1:0] com_map;
  logic [SLPC_NUM_SEG-1:0]   seg_drive;
  modport decoder (input pin_control, output com_drive, output com_map, output seg_drive);
  modport top (output pin_control, input com_drive, input com_map, input seg_drive);
endinterface : slpc_cfg_if
`default_nettype wire

// ---- hw/slpc_pin_decode.sv ----
// Combinational decoder: pin control value to common and segment usage.
// Assumes the top registers every result before it reaches a pin.
`timescale 1ns/1ns
`default_nettype none
module slpc_pin_decode (
  slpc_cfg_if.decoder cfg
);
  import slpc_pkg::*;

  // Group g spans pins 4g+1..4g+4, group 8 spans pins 33..40
  function automatic logic group_on(input logic [3:0] sgs, input int g);
    logic [3:0] lim;
    lim = 4'h0;
    if (sgs[SLPC_SGS_MSB]) begin
      group_on = (g != 0) || sgs[0];                              // see [RULE9]
    end else begin
      lim = 4'(SLPC_NUM_GROUP - 1 - g);
      group_on = (sgs[2:0] != 3'h0) && ({1'b0, sgs[2:0]} > lim);  // see [RULE8]
    end
  endfunction : group_on

  logic [3:0] sgs;
  logic       cpar;
  slpc_duty_t duty;
  assign sgs  = cfg.pin_control[SLPC_SGS_MSB:0];
  assign cpar = cfg.pin_control[SLPC_CPAR_BIT];
  assign duty = slpc_duty_t'(cfg.pin_control[SLPC_DUTY_HI_BIT:SLPC_DUTY_LO_BIT]);

  genvar gi;
  generate
    for (gi = 0; gi < SLPC_NUM_SEG; gi++) begin : g_seg
      localparam int GRP = (gi >= 32) ? 8 : gi / 4;
      assign cfg.seg_drive[gi] = group_on(sgs, GRP);
    end
  endgenerate

  // com_map holds, per line, the 2-bit index of the waveform it copies
  always_comb begin
    cfg.com_drive = 4'h0;
    cfg.com_map   = 8'hE4;
    case (duty)
      SLPC_DUTY_STATIC: begin
        if (cpar) begin
          cfg.com_drive = 4'hF;                                   // see [RULE2]
          cfg.com_map   = 8'h00;
        end else begin
          cfg.com_drive = 4'h1;                                   // see [RULE1]
        end
      end
      SLPC_DUTY_HALF: begin
        if (cpar) begin
          cfg.com_drive = 4'hF;                                   // see [RULE4]
          cfg.com_map   = 8'hA0;
        end else begin
          cfg.com_drive = 4'h3;                                   // see [RULE3]
        end
      end
      SLPC_DUTY_THIRD: begin
        cfg.com_drive = cpar ? 4'hF : 4'h7;                       // see [RULE5]
      end
      SLPC_DUTY_QUARTER: cfg.com_drive = 4'hF;                    // see [RULE6]
      default:           cfg.com_drive = 4'h0;
    endcase
    if (sgs == 4'h0) begin
      cfg.com_drive = 4'h0;                                       // see [RULE7]
    end
  end

endmodule : slpc_pin_decode
`default_nettype wire

// ---- hw/slpc_pkg.sv ----
// Package for the segment LCD pin and activation control block.
// Assumes an APB slave with 32-bit data and one aligned word per register.
package slpc_pkg;

  // Register byte addresses
  localparam logic [7:0] SLPC_ADDR_PIN_CONTROL = 8'h00;
  localparam logic [7:0] SLPC_ADDR_LCD_CONTROL = 8'h04;
  localparam logic [7:0] SLPC_ADDR_STATUS      = 8'h08;

  // Pin control fields
  localparam int SLPC_DUTY_HI_BIT   = 7;
  localparam int SLPC_DUTY_LO_BIT   = 6;
  localparam int SLPC_CPAR_BIT      = 5;
  localparam int SLPC_SGS_MSB       = 3;
  localparam logic [7:0] SLPC_PIN_CONTROL_WMASK = 8'hEF;

  // Control register fields
  localparam int SLPC_RSVD_BIT      = 7;
  localparam int SLPC_DIV_BIT       = 6;
  localparam int SLPC_ACT_BIT       = 5;
  localparam int SLPC_SHOW_BIT      = 4;
  localparam logic [7:0] SLPC_LCD_CONTROL_WMASK = 8'h7F;
  localparam logic [7:0] SLPC_LCD_CONTROL_RSVD  = 8'h80;

  // Reset values
  localparam logic [7:0] SLPC_PIN_CONTROL_RST = 8'h00;
  localparam logic [7:0] SLPC_LCD_CONTROL_RST = 8'h00;

  // Pin counts
  localparam int SLPC_NUM_SEG   = 40;
  localparam int SLPC_NUM_GROUP = 9;
  localparam int SLPC_NUM_COM   = 4;

  typedef enum logic [1:0] {
    SLPC_DUTY_STATIC  = 2'b00,
    SLPC_DUTY_HALF    = 2'b01,
    SLPC_DUTY_THIRD   = 2'b10,
    SLPC_DUTY_QUARTER = 2'b11
  } slpc_duty_t;

  typedef enum logic [1:0] {
    SLPC_APB_IDLE   = 2'b00,
    SLPC_APB_ACCESS = 2'b01
  } slpc_apb_state_t;

endpackage : slpc_pkg

// ---- hw/slpc_top.sv ----
// Segment LCD pin and activation control with APB register access.
// Assumes a phase generator supplies per-common waveforms and segment data.
//
// Summary of operation
// [RULE1] Static duty, no parallel: only common line 1 drives; 2-4 are ports.
// [RULE2] Static duty with parallel: lines 2, 3, 4 copy line 1.
// [RULE3] Half duty, no parallel: lines 1 and 2 drive; 3 and 4 are ports.
// [RULE4] Half duty with parallel: line 4 copies 3, line 2 copies 1.
// [RULE5] Third duty drives 1-3; line 4 port, or unused by software if parallel.
// [RULE6] Duty field picks static, half, third, quarter; quarter drives all four.
// [RULE7] Segment selection zero hands all common lines to ports.
// [RULE8] Selection steps enable segment groups from pin 40 downward.
// [RULE9] Top selection bit set: low bit picks whether pins 4-1 also drive.
// [RULE10] Software uses external bus mode only with selection zero.
// [RULE11] Control bit 7 reads as one; software writes zero.
// [RULE12] Divider-connect bit connects the bias resistance to supply.
// [RULE13] Inactive or standby forces the bias resistance off.
// [RULE14] Clearing activate halts driving; setting it runs the controller.
// [RULE15] Halting keeps every configuration register unchanged.
// [RULE16] Show bit zero drives blank; one drives display memory.
//
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/1ns
`default_nettype none
module slpc_top (
  // Clock and reset
  input  wire logic                           clk_sys_i,
  input  wire logic                           rst_i,
  // APB slave
  input  wire logic                           psel_i,
  input  wire logic                           penable_i,
  input  wire logic                           pwrite_i,
  input  wire logic [7:0]                     paddr_i,
  input  wire logic [31:0]                    pwdata_i,
  output logic      [31:0]                    prdata_o,
  output logic                                pready_o,
  output logic                                pslverr_o,
  // Chip state, asynchronous to this block
  input  wire logic                           standby_i,
  // Waveform sources from the phase generator, same clock
  input  wire logic [slpc_pkg::SLPC_NUM_COM-1:0] com_wave_i,
  input  wire logic [slpc_pkg::SLPC_NUM_SEG-1:0] seg_data_i,
  input  wire logic [slpc_pkg::SLPC_NUM_SEG-1:0] seg_blank_i,
  // Panel side
  output logic      [slpc_pkg::SLPC_NUM_COM-1:0] com_o,
  output logic      [slpc_pkg::SLPC_NUM_COM-1:0] com_drive_o,
  output logic      [slpc_pkg::SLPC_NUM_SEG-1:0] segment_lines_o,
  output logic      [slpc_pkg::SLPC_NUM_SEG-1:0] seg_drive_o,
  output logic                                divider_connect_o,
  output logic                                running_o
);
  import slpc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers and APB slave

  logic [7:0]      lcd_pin_control, next_lcd_pin_control;
  logic [7:0]      lcd_control,     next_lcd_control;
  slpc_apb_state_t apb_state,       next_apb_state;
  logic [31:0]     next_prdata;
  logic            next_pready, next_pslverr;
  logic            stby_meta, stby_sync;

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == SLPC_ADDR_PIN_CONTROL) || (a == SLPC_ADDR_LCD_CONTROL) ||
               (a == SLPC_ADDR_STATUS);
  endfunction : addr_hit

  logic wr_take, rd_take;
  assign wr_take = (apb_state == SLPC_APB_ACCESS) && psel_i && penable_i && pwrite_i;
  assign rd_take = (apb_state == SLPC_APB_ACCESS) && psel_i && penable_i && !pwrite_i;

  // Registers change only by writes; halting never touches them
  always_comb begin
    next_lcd_pin_control = lcd_pin_control;
    next_lcd_control     = lcd_control;
    next_apb_state       = apb_state;
    next_prdata          = 32'h0000_0000;
    next_pready          = 1'b0;
    next_pslverr         = 1'b0;
    case (apb_state)
      SLPC_APB_IDLE: begin
        if (psel_i && !penable_i) begin
          next_apb_state = SLPC_APB_ACCESS;
          next_pready    = 1'b1;
          next_pslverr   = !addr_hit(paddr_i);
          case (paddr_i)
            SLPC_ADDR_PIN_CONTROL: next_prdata = {24'h00_0000, lcd_pin_control};
            SLPC_ADDR_LCD_CONTROL: next_prdata = {24'h00_0000,
                                                 lcd_control | SLPC_LCD_CONTROL_RSVD}; // see [RULE11]
            SLPC_ADDR_STATUS:      next_prdata = {30'h0, divider_connect_o,
                                                  running_o};
            default:               next_prdata = 32'h0000_0000;
          endcase
        end
      end
      SLPC_APB_ACCESS: begin
        next_apb_state = SLPC_APB_IDLE;
        if (wr_take && paddr_i == SLPC_ADDR_PIN_CONTROL) begin
          next_lcd_pin_control = pwdata_i[7:0] & SLPC_PIN_CONTROL_WMASK;
        end
        if (wr_take && paddr_i == SLPC_ADDR_LCD_CONTROL) begin
          next_lcd_control = pwdata_i[7:0] & SLPC_LCD_CONTROL_WMASK;  // see [RULE15]
        end
      end
      default: next_apb_state = SLPC_APB_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      lcd_pin_control <= SLPC_PIN_CONTROL_RST;
      lcd_control     <= SLPC_LCD_CONTROL_RST;
      apb_state       <= SLPC_APB_IDLE;
      prdata_o        <= 32'h0000_0000;
      pready_o        <= 1'b0;
      pslverr_o       <= 1'b0;
      stby_meta       <= 1'b0;
      stby_sync       <= 1'b0;
    end else begin
      lcd_pin_control <= next_lcd_pin_control;
      lcd_control     <= next_lcd_control;
      apb_state       <= next_apb_state;
      prdata_o        <= next_prdata;
      pready_o        <= next_pready;
      pslverr_o       <= next_pslverr;
      stby_meta       <= standby_i;
      stby_sync       <= stby_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin decode and output stage

  slpc_cfg_if cfg ();
  assign cfg.pin_control = lcd_pin_control;

  slpc_pin_decode u_decode (
    .cfg (cfg.decoder)
  );

  logic                    act, show, div;
  logic                    next_running, next_divider;
  logic [SLPC_NUM_COM-1:0] next_com, next_com_drive;
  logic [SLPC_NUM_SEG-1:0] next_seg, next_seg_drive;
  assign act  = lcd_control[SLPC_ACT_BIT];
  assign show = lcd_control[SLPC_SHOW_BIT];
  assign div  = lcd_control[SLPC_DIV_BIT];

  // Port-mode pins keep their enable low so the port logic owns them
  always_comb begin
    next_running   = act;                                         // see [RULE14]
    next_divider   = div && act && !stby_sync;                    // see [RULE12] [RULE13]
    next_com       = 4'h0;
    next_com_drive = 4'h0;
    next_seg       = '0;
    next_seg_drive = '0;
    if (act) begin
      next_com_drive = cfg.com_drive;
      next_seg_drive = cfg.seg_drive;
      for (int i = 0; i < SLPC_NUM_COM; i++) begin
        next_com[i] = cfg.com_drive[i] & com_wave_i[cfg.com_map[2*i +: 2]]; // see [RULE4]
      end
      next_seg = cfg.seg_drive & (show ? seg_data_i : seg_blank_i); // see [RULE16]
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      running_o         <= 1'b0;
      divider_connect_o <= 1'b0;
      com_o             <= 4'h0;
      com_drive_o       <= 4'h0;
      segment_lines_o   <= '0;
      seg_drive_o       <= '0;
    end else begin
      running_o         <= next_running;
      divider_connect_o <= next_divider;
      com_o             <= next_com;
      com_drive_o       <= next_com_drive;
      segment_lines_o   <= next_seg;
      seg_drive_o       <= next_seg_drive;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Duty with parallel bit as one field, and the segment selection
  logic [2:0] duty_par;
  logic [3:0] sel;
  assign duty_par = lcd_pin_control[SLPC_DUTY_HI_BIT:SLPC_CPAR_BIT];
  assign sel      = lcd_pin_control[SLPC_SGS_MSB:0];

  property p_static_single;
    @(posedge clk_sys_i) disable iff (rst_i)
    (act && duty_par == {SLPC_DUTY_STATIC, 1'b0} && sel != 4'h0)
      |=> com_drive_o == 4'h1;
  endproperty
  a_static_single: assert property (p_static_single)  // see [RULE1]
    else $error("static com drive");

  // Output lags the wave by one edge, so compare with the sampled wave
  property p_static_par;
    @(posedge clk_sys_i) disable iff (rst_i)
    (act && duty_par == {SLPC_DUTY_STATIC, 1'b1} && sel != 4'h0)
      |=> com_o == {4{$past(com_wave_i[0])}} && com_drive_o == 4'hF;
  endproperty
  a_static_par: assert property (p_static_par)  // see [RULE2]
    else $error("static parallel copy");

  property p_half;
    @(posedge clk_sys_i) disable iff (rst_i)
    (act && duty_par == {SLPC_DUTY_HALF, 1'b0} && sel != 4'h0)
      |=> com_drive_o == 4'h3;
  endproperty
  a_half: assert property (p_half)  // see [RULE3]
    else $error("half duty drive");

  property p_half_par;
    @(posedge clk_sys_i) disable iff (rst_i)
    (act && duty_par == {SLPC_DUTY_HALF, 1'b1} && sel != 4'h0)
      |=> com_o[1] == $past(com_wave_i[0]) && com_o[3] == $past(com_wave_i[2]);
  endproperty
  a_half_par: assert property (p_half_par)  // see [RULE4]
    else $error("half parallel copy");

  property p_third;
    @(posedge clk_sys_i) disable iff (rst_i)
    (act && duty_par == {SLPC_DUTY_THIRD, 1'b0} && sel != 4'h0)
      |=> com_drive_o == 4'h7;
  endproperty
  a_third: assert property (p_third)  // see [RULE5]
    else $error("third duty drive");

  // Parallel bit must not matter in quarter duty
  property p_quarter;
    @(posedge clk_sys_i) disable iff (rst_i)
    (act && duty_par[2:1] == SLPC_DUTY_QUARTER && sel != 4'h0)
      |=> com_drive_o == 4'hF;
  endproperty
  a_quarter: assert property (p_quarter)  // see [RULE6]
    else $error("quarter duty drive");

  property p_com_port;
    @(posedge clk_sys_i) disable iff (rst_i)
    (sel == 4'h0) |=> com_drive_o == 4'h0 && seg_drive_o == '0;
  endproperty
  a_com_port: assert property (p_com_port)  // see [RULE7]
    else $error("zero selection not ports");

  // Any stepped selection drives pin 40 and leaves pin 1 a port
  property p_seg_steps;
    @(posedge clk_sys_i) disable iff (rst_i)
    (act && !sel[SLPC_SGS_MSB] && sel != 4'h0)
      |=> seg_drive_o[SLPC_NUM_SEG-1] && !seg_drive_o[0];
  endproperty
  a_seg_steps: assert property (p_seg_steps)  // see [RULE8]
    else $error("segment step selection");

  property p_seg_top;
    @(posedge clk_sys_i) disable iff (rst_i)
    (act && sel[SLPC_SGS_MSB])
      |=> seg_drive_o[SLPC_NUM_SEG-1] && seg_drive_o[0] == $past(sel[0]);
  endproperty
  a_seg_top: assert property (p_seg_top)  // see [RULE9]
    else $error("top selection low pins");

  property p_bias_on;
    @(posedge clk_sys_i) disable iff (rst_i)
    (act && div && !stby_sync) |=> divider_connect_o;
  endproperty
  a_bias_on: assert property (p_bias_on)  // see [RULE12]
    else $error("bias not connected");

  property p_bias_off;
    @(posedge clk_sys_i) disable iff (rst_i)
    (!act || stby_sync) |=> !divider_connect_o;
  endproperty
  a_bias_off: assert property (p_bias_off)  // see [RULE13]
    else $error("bias left connected");

  property p_run;
    @(posedge clk_sys_i) disable iff (rst_i)
    act |=> running_o;
  endproperty
  a_run: assert property (p_run)  // see [RULE14]
    else $error("not running while active");

  property p_halt;
    @(posedge clk_sys_i) disable iff (rst_i)
    !act |=> !running_o && com_drive_o == 4'h0 && seg_drive_o == '0;
  endproperty
  a_halt: assert property (p_halt)  // see [RULE14]
    else $error("outputs driven while halted");

  property p_blank;
    @(posedge clk_sys_i) disable iff (rst_i)
    (act && !show) |=> segment_lines_o == ($past(seg_blank_i) & seg_drive_o);
  endproperty
  a_blank: assert property (p_blank)  // see [RULE16]
    else $error("blank pattern not shown");

  property p_show;
    @(posedge clk_sys_i) disable iff (rst_i)
    (act && show) |=> segment_lines_o == ($past(seg_data_i) & seg_drive_o);
  endproperty
  a_show: assert property (p_show)  // see [RULE16]
    else $error("memory data not shown");

  property p_rsvd;
    @(posedge clk_sys_i) disable iff (rst_i)
    (rd_take && paddr_i == SLPC_ADDR_LCD_CONTROL) |-> prdata_o[SLPC_RSVD_BIT];
  endproperty
  a_rsvd: assert property (p_rsvd)  // see [RULE11]
    else $error("reserved bit read as zero");

endmodule : slpc_top
`default_nettype wire

// ---- testbench/slpc_panel.sv ----
// Glass panel model: sees only the lines that the block drives.
// Assumes registered block outputs on the same clock; it drives nothing back.
`timescale 1ns/1ns
`default_nettype none
module slpc_panel (
  // Clock
  input  wire logic        clk_sys_i,
  // Lines from the block
  input  wire logic [3:0]  com_i,
  input  wire logic [3:0]  com_drive_i,
  input  wire logic [39:0] seg_i,
  input  wire logic [39:0] seg_drive_i,
  // What the glass shows
  output logic      [3:0]  seen_com_o,
  output logic      [39:0] seen_seg_o
);
  // Port-use lines are not wired to the glass; in third duty line 4 reaches the glass only with parallel
  always_ff @(posedge clk_sys_i) begin
    seen_com_o <= com_i & com_drive_i;
    seen_seg_o <= seg_i & seg_drive_i;
  end
endmodule : slpc_panel
`default_nettype wire

// ---- testbench/tb.sv ----
// Self-checking bench: APB master, reference model, panel model.
// Assumes the single-cycle APB answer and one-edge output latency.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb;
  import slpc_pkg::*;
  logic        clk_sys_i, rst_i, psel, penable, pwrite, standby, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  com_wave, com, com_drive, seen_com;
  logic [39:0] seg_data, seg_blank, seg, seg_drive, seen_seg;
  logic        divider, running;
  int          n_mismatch, checks_done, cyc;
  logic [31:0] rnd;

  slpc_top DUT (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .standby_i(standby), .com_wave_i(com_wave),
    .seg_data_i(seg_data), .seg_blank_i(seg_blank), .com_o(com), .com_drive_o(com_drive),
    .segment_lines_o(seg), .seg_drive_o(seg_drive), .divider_connect_o(divider),
    .running_o(running));
  slpc_panel panel (.clk_sys_i(clk_sys_i), .com_i(com), .com_drive_i(com_drive),
    .seg_i(seg), .seg_drive_i(seg_drive), .seen_com_o(seen_com), .seen_seg_o(seen_seg));

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h0400_0007 : 32'h0000_0000);
  endfunction : lfsr

  function automatic logic [3:0] exp_drv(int p);
    int d = (p >> 6) & 3;
    int c = (p >> 5) & 1;
    if ((p & 15) == 0) return 4'h0;
    case (d)
      0: return c ? 4'hF : 4'h1;
      1: return c ? 4'hF : 4'h3;
      2: return c ? 4'hF : 4'h7;
      default: return 4'hF;
    endcase
  endfunction : exp_drv

  function automatic logic [39:0] exp_seg(int p);
    int g = p & 15;
    int n;
    n = (g == 0) ? 0 : (g < 8) ? 4 * (g + 1) : ((g & 1) ? 40 : 36);
    return ~(40'hFF_FFFF_FFFF >> n);
  endfunction : exp_seg

  function automatic logic [3:0] exp_com(int p, logic [3:0] w);
    int d = (p >> 6) & 3;
    int c = (p >> 5) & 1;
    if (exp_drv(p) == 4'h0) return 4'h0;
    if (c == 1 && d == 0) return {4{w[0]}};
    if (c == 1 && d == 1) return {w[2], w[2], w[0], w[0]};
    return w & exp_drv(p);
  endfunction : exp_com

  task automatic stop_test();
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge clk_sys_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the answer
    do begin
      @(posedge clk_sys_i);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Hang guard, well above the ~2450 cycles of the run
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 10000) begin
      n_mismatch++;
      stop_test();
    end
  end

  initial begin
    int p, c;
    logic [31:0] rd;
    logic er;
    n_mismatch = 0; checks_done = 0; cyc = 0; rnd = 32'hf47b_85fd;
    rst_i = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0000_0000; standby = 1'b0; com_wave = 4'h0;
    seg_data = 40'h00_0000_0000; seg_blank = 40'h00_0000_0000;
    repeat (5) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    `CHK("reset drive", 4'h0, com_drive)
    apb(1'b0, SLPC_ADDR_PIN_CONTROL, 32'h0, rd, er);
    `CHK("pin reset", 32'h0000_0000, rd)
    apb(1'b0, SLPC_ADDR_LCD_CONTROL, 32'h0, rd, er);
    `CHK("lcd reset", 32'h0000_0080, rd)
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF, rd, er);
    `CHK("unmapped err", 1'b1, er)
    // Every duty, parallel and selection combination, random levels
    for (int i = 0; i < 128; i++) begin
      rnd = lfsr(rnd);
      p = ((i & 3) << 6) | (((i >> 2) & 1) << 5) | ((i >> 3) & 15);
      // Activation pattern independent of duty, so every duty runs active
      c = (rnd & 32'h50) | ((i % 5 != 0) ? 32'h20 : 0);
      standby <= (i % 16 == 5);
      com_wave <= rnd[15:12];
      seg_data <= {rnd, rnd[7:0]};
      seg_blank <= ~{rnd[7:0], rnd};
      apb(1'b1, SLPC_ADDR_PIN_CONTROL, p, rd, er);
      apb(1'b1, SLPC_ADDR_LCD_CONTROL, c, rd, er);
      repeat (4) @(posedge clk_sys_i);
      `CHK("running", c[5], running)
      `CHK("divider", c[6] & c[5] & ~standby, divider)
      // External bus use is only legal while every panel pin is released
      if ((p & 15) == 0) `CHK("bus pins free", 44'h0, {com_drive, seg_drive})
      if (c[5] && !standby) begin
        `CHK("com drive", exp_drv(p), com_drive)
        `CHK("com level", exp_com(p, com_wave), com)
        `CHK("panel com", exp_com(p, com_wave) & exp_drv(p), seen_com)
        `CHK("seg drive", exp_seg(p), seg_drive)
        `CHK("seg level", (c[4] ? seg_data : seg_blank) & exp_seg(p), seg)
        `CHK("panel seg", (c[4] ? seg_data : seg_blank) & exp_seg(p), seen_seg)
      end
      apb(1'b0, SLPC_ADDR_PIN_CONTROL, 32'h0, rd, er);
      `CHK("pin back", p, rd)
      apb(1'b0, SLPC_ADDR_LCD_CONTROL, 32'h0, rd, er);
      `CHK("lcd back", c | 32'h80, rd)
      apb(1'b0, SLPC_ADDR_STATUS, 32'h0, rd, er);
      `CHK("status", {30'h0, c[6] & c[5] & ~standby, c[5]}, rd)
    end
    stop_test();
  end
endmodule : tb
`default_nettype wire
